// ---- logic/sfdpt_pkg.sv ----
// Package for the discoverable-parameter table link: table bytes, opcodes, timing.
// Assumes a single 40 MHz system clock shared by both ends; serial link is logic-level.
package sfdpt_pkg;
    // Timing
    localparam int CLK_MHZ         = 40;
    localparam int DPD_ENTER_US    = 3;
    localparam int DPD_EXIT_US     = 10;
    localparam int SUSPEND_US      = 25;
    localparam int DPD_ENTER_CYC   = DPD_ENTER_US * CLK_MHZ;
    localparam int DPD_EXIT_CYC    = DPD_EXIT_US * CLK_MHZ;
    localparam int SUSPEND_CYC     = SUSPEND_US * CLK_MHZ;
    localparam int SCK_DIV         = 2;
    // Opcodes
    localparam logic [7:0] OP_READ_TABLE  = 8'h5A;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_DPD_ENTER   = 8'hB9;
    localparam logic [7:0] OP_DPD_EXIT    = 8'hAB;
    localparam logic [7:0] OP_RST_EN      = 8'h66;
    localparam logic [7:0] OP_RST_MEM     = 8'h99;
    localparam logic [7:0] OP_SUSPEND     = 8'hB0;
    localparam logic [7:0] OP_RESUME      = 8'h30;
    localparam logic [7:0] FILL           = 8'hFF;
    localparam int         STATUS_BUSY_BIT = 0;
    // Table base addresses
    localparam logic [23:0] MAP_BASE  = 24'h000100;
    localparam logic [23:0] MAP_LAST  = 24'h000117;
    localparam logic [23:0] VEND_BASE = 24'h000200;
    localparam logic [23:0] VEND_LAST = 24'h00024B;
    localparam logic [23:0] ADDR4_BASE = 24'h00006E;
    // Identity bytes: arbitrary neutral values
    localparam logic [7:0] ID_MAKER = 8'h5C;
    localparam logic [7:0] ID_TYPE  = 8'h11;
    localparam logic [7:0] ID_PART  = 8'h22;
    // Sector map 100H..117H
    localparam logic [7:0] MAP_ROM [0:23] = '{
        8'hFF, 8'h00, 8'h04, 8'hFF,
        8'hF3, 8'h7F, 8'h00, 8'h00,
        8'hF5, 8'h7F, 8'h00, 8'h00,
        8'hF9, 8'hFF, 8'h1D, 8'h00,
        8'hF5, 8'h7F, 8'h00, 8'h00,
        8'hF3, 8'h7F, 8'h00, 8'h00};
    // Vendor area 200H..24BH; supply-voltage bytes read as fill
    localparam logic [7:0] VEND_ROM [0:75] = '{
        ID_MAKER, ID_TYPE, ID_PART, 8'hFF,
        8'hB9, 8'hDF, 8'hFD, 8'hFF,
        8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'h32, 8'hFF, 8'h0A, 8'h12,
        8'h23, 8'h46, 8'hFF, 8'h0F,    // see RULE9
        8'h19, 8'h32, 8'h0F, 8'h19,    // see RULE9 see RULE11
        8'h19, 8'h03, 8'h0A, 8'hFF,    // see RULE10 see RULE11
        8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'h00, 8'h66, 8'h99, 8'h38,    // see RULE15
        8'hFF, 8'h05, 8'h01, 8'h35,
        8'h06, 8'h04, 8'h02, 8'h32,    // see RULE12
        8'hB0, 8'h30, 8'h72, 8'h42,    // see RULE12 see RULE13
        8'h8D, 8'hE8, 8'h98, 8'h88,    // see RULE13 see RULE14
        8'hA5, 8'h85, 8'hC0, 8'h9F,    // see RULE14
        8'hAF, 8'h5A, 8'hB9, 8'hAB,    // see RULE15
        8'h06, 8'hEC, 8'h06, 8'h0C,    // see RULE16
        8'h00, 8'h03, 8'h08, 8'h0B,    // see RULE17
        8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'h07, 8'hFF, 8'hFF};   // see RULE18
    // Four-byte addressing bytes 6EH, 6FH
    localparam logic [7:0] ADDR4_EXIT  = 8'hC0;
    localparam logic [7:0] ADDR4_ENTER = 8'h80;
    // Device states
    typedef enum logic [2:0] {
        SFDPT_D_CMD   = 3'b000,
        SFDPT_D_ADDR  = 3'b001,
        SFDPT_D_DUMMY = 3'b010,
        SFDPT_D_DATA  = 3'b011,
        SFDPT_D_STAT  = 3'b100,
        SFDPT_D_IGN   = 3'b101
    } sfdpt_dev_state_t;
    // Host states
    typedef enum logic [2:0] {
        SFDPT_H_IDLE  = 3'b000,
        SFDPT_H_SHIFT = 3'b001,
        SFDPT_H_DONE  = 3'b010,
        SFDPT_H_WAIT  = 3'b011
    } sfdpt_host_state_t;
endpackage : sfdpt_pkg

// ---- logic/sfdpt_link_if.sv ----
// Serial link between table device and host controller.
// Assumes both ends sit on the same clock; mode 0 single-bit signalling.
interface sfdpt_link_if;
    logic cs_n;   // Chip select, active low
    logic sck;    // Serial clock from host
    logic mosi;   // Host to device
    logic miso;   // Device to host
    modport dev  (input cs_n, input sck, input mosi, output miso);
    modport host (output cs_n, output sck, output mosi, input miso);
endinterface : sfdpt_link_if

// ---- logic/sfdpt_device.sv ----
// Table device end: decodes serial commands and serves the parameter table.
// Assumes host drives mode 0 (sample on sck rise, shift on fall); pins pass
// two flip-flops before use.
// Functional notes
// RULE1: map header byte reads all ones
// RULE2: config id zero, region count four
// RULE3: region descriptor: erase bitmap, size field
// RULE4: five regions with documented codes and sizes
// RULE5: interface capability byte B9H
// RULE6: second capability byte DFH
// RULE7: protection capability byte FDH
// RULE8: typical times in plain hexadecimal
// RULE9: maximum times encoded; host times out
// RULE10: power-down enter 3us, exit 10us
// RULE11: suspend within 25us, reported 19H
// RULE12: program and suspend/resume opcodes listed
// RULE13: block protection opcodes listed
// RULE14: security ID opcodes listed
// RULE15: power-down opcodes and 66/99 reset
// RULE16: wrap burst opcodes, six dummy clocks
// RULE17: read 03H no dummy, 0BH eight
// RULE18: security ID size 07FFH
// RULE19: reserved vendor bytes read as ones
// RULE20: four-byte addressing unsupported
// RULE21: status bit 0 shows busy
// RULE22: table read returns ascending bytes
//
// Added by the designer: the address map and the address-and-strobe port.
module sfdpt_device (
    input  wire logic     clk,
    input  wire logic     rst,
    sfdpt_link_if.dev     link,
    input  wire logic     busy_in,
    output logic          dpd_active,
    output logic          in_reset
);
    typedef struct packed {
        logic [1:0]                 cs_s;
        logic [1:0]                 sck_s;
        logic [1:0]                 mosi_s;
        logic                       sck_d;
        sfdpt_pkg::sfdpt_dev_state_t st;
        logic [2:0]                 bitn;
        logic [7:0]                 shreg;
        logic [1:0]                 abyte;
        logic [23:0]                addr;
        logic [7:0]                 outb;
        logic                       miso;
        logic                       rst_armed;
        logic                       dpd;
        logic                       write_in_progress_flag;
        logic [9:0]                 dpd_cnt;
        logic                       rst_pend;
    } sfdpt_dev_s_t;

    sfdpt_dev_s_t s;
    sfdpt_dev_s_t next_s;

    // Table lookup; unmapped and reserved bytes read as ones
    function automatic logic [7:0] table_byte(input logic [23:0] a);
        logic [23:0] o;
        o = 24'h0;
        table_byte = sfdpt_pkg::FILL;                          // see RULE19
        if (a >= sfdpt_pkg::MAP_BASE && a <= sfdpt_pkg::MAP_LAST) begin
            o = a - sfdpt_pkg::MAP_BASE;
            table_byte = sfdpt_pkg::MAP_ROM[o[4:0]];           // see RULE1 see RULE2 see RULE3 see RULE4
        end else if (a >= sfdpt_pkg::VEND_BASE && a <= sfdpt_pkg::VEND_LAST) begin
            o = a - sfdpt_pkg::VEND_BASE;
            table_byte = sfdpt_pkg::VEND_ROM[o[6:0]];          // see RULE5 see RULE6 see RULE7 see RULE8
        end else if (a == sfdpt_pkg::ADDR4_BASE) begin
            table_byte = sfdpt_pkg::ADDR4_EXIT;                // see RULE20
        end else if (a == sfdpt_pkg::ADDR4_BASE + 24'h1) begin
            table_byte = sfdpt_pkg::ADDR4_ENTER;               // see RULE20
        end
    endfunction : table_byte

    logic cs_act;
    logic rise;
    logic fall;
    logic bit_in;
    logic [7:0] byte_in;

    // Edge detect on synchronised copies only
    always_comb begin
        cs_act  = ~s.cs_s[1];
        rise    = s.sck_s[1] & ~s.sck_d;
        fall    = ~s.sck_s[1] & s.sck_d;
        bit_in  = s.mosi_s[1];
        byte_in = {s.shreg[6:0], bit_in};
    end

    // Command decode and shift engine
    always_comb begin
        next_s        = s;
        next_s.cs_s   = {s.cs_s[0], link.cs_n};
        next_s.sck_s  = {s.sck_s[0], link.sck};
        next_s.mosi_s = {s.mosi_s[0], link.mosi};
        next_s.sck_d  = s.sck_s[1];
        next_s.write_in_progress_flag    = busy_in | s.dpd_cnt != 10'h000;
        if (s.dpd_cnt != 10'h000) begin
            next_s.dpd_cnt = s.dpd_cnt - 10'h001;             // see RULE10
        end
        next_s.rst_pend = 1'b0;
        if (!cs_act) begin
            next_s.st   = sfdpt_pkg::SFDPT_D_CMD;
            next_s.bitn = 3'h0;
            next_s.miso = 1'b0;
        end else if (rise) begin
            next_s.shreg = byte_in;
            next_s.bitn  = s.bitn + 3'h1;
            if (s.bitn == 3'h7) begin
                case (s.st)
                    sfdpt_pkg::SFDPT_D_CMD: begin
                        next_s.st = sfdpt_pkg::SFDPT_D_IGN;
                        next_s.rst_armed = 1'b0;
                        if (s.dpd) begin
                            if (byte_in == sfdpt_pkg::OP_DPD_EXIT) begin
                                next_s.dpd = 1'b0;             // see RULE15
                                next_s.dpd_cnt = 10'(sfdpt_pkg::DPD_EXIT_CYC);
                            end
                        end else begin
                            case (byte_in)
                                sfdpt_pkg::OP_READ_TABLE: begin
                                    next_s.st    = sfdpt_pkg::SFDPT_D_ADDR;
                                    next_s.abyte = 2'h0;
                                end
                                sfdpt_pkg::OP_READ_STATUS: begin
                                    next_s.st   = sfdpt_pkg::SFDPT_D_STAT;
                                    next_s.outb = {7'h00, s.write_in_progress_flag}; // see RULE21
                                end
                                sfdpt_pkg::OP_DPD_ENTER: begin
                                    next_s.dpd = 1'b1;         // see RULE15
                                    next_s.dpd_cnt = 10'(sfdpt_pkg::DPD_ENTER_CYC);
                                end
                                sfdpt_pkg::OP_RST_EN: begin
                                    next_s.rst_armed = 1'b1;   // see RULE15
                                end
                                sfdpt_pkg::OP_RST_MEM: begin
                                    next_s.rst_pend = s.rst_armed;
                                end
                                default: begin
                                    next_s.st = sfdpt_pkg::SFDPT_D_IGN;
                                end
                            endcase
                        end
                    end
                    sfdpt_pkg::SFDPT_D_ADDR: begin
                        next_s.addr  = {s.addr[15:0], byte_in};
                        next_s.abyte = s.abyte + 2'h1;
                        if (s.abyte == 2'h2) begin
                            next_s.st = sfdpt_pkg::SFDPT_D_DUMMY;
                        end
                    end
                    sfdpt_pkg::SFDPT_D_DUMMY: begin
                        next_s.st   = sfdpt_pkg::SFDPT_D_DATA;
                        next_s.outb = table_byte(s.addr);      // see RULE22
                    end
                    sfdpt_pkg::SFDPT_D_DATA: begin
                        next_s.addr = s.addr + 24'h1;          // see RULE22
                        next_s.outb = table_byte(s.addr + 24'h1);
                    end
                    sfdpt_pkg::SFDPT_D_STAT: begin
                        next_s.outb = {7'h00, s.write_in_progress_flag};
                    end
                    default: begin
                        next_s.st = sfdpt_pkg::SFDPT_D_IGN;
                    end
                endcase
            end
        end else if (fall) begin
            // Drive data on falling edge so host samples a stable bit
            if (s.st == sfdpt_pkg::SFDPT_D_DATA || s.st == sfdpt_pkg::SFDPT_D_STAT) begin
                next_s.miso = s.outb[3'h7 - s.bitn];
            end
        end
        if (s.rst_pend) begin
            next_s.dpd       = 1'b0;
            next_s.rst_armed = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '{cs_s: 2'h3, sck_s: 2'h0, mosi_s: 2'h0, sck_d: 1'b0,
                   st: sfdpt_pkg::SFDPT_D_CMD, bitn: 3'h0, shreg: 8'h00,
                   abyte: 2'h0, addr: 24'h0, outb: 8'h00, miso: 1'b0,
                   rst_armed: 1'b0, dpd: 1'b0, write_in_progress_flag: 1'b0, dpd_cnt: 10'h000,
                   rst_pend: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign link.miso  = s.miso;
    assign dpd_active = s.dpd;
    assign in_reset   = s.rst_pend;
endmodule : sfdpt_device

// ---- logic/sfdpt_host.sv ----
// Host controller end: issues table reads and single-byte commands on the link.
// Assumes device answers per the table read protocol; miso passes a 2-stage sync.
module sfdpt_host (
    input  wire logic        clk,
    input  wire logic        rst,
    sfdpt_link_if.host       link,
    input  wire logic        start,
    input  wire logic [7:0]  opcode,
    input  wire logic [23:0] addr,
    input  wire logic [7:0]  nbytes,
    output logic             ready,
    output logic             rd_valid,
    output logic [7:0]       rd_data
);
    typedef struct packed {
        sfdpt_pkg::sfdpt_host_state_t st;
        logic [1:0]  miso_s;
        logic [47:0] tx;
        logic [7:0]  nbits;
        logic [7:0]  rx;
        logic [2:0]  rxn;
        logic [7:0]  left;
        logic [1:0]  div;
        logic        sck;
        logic        cs_n;
        logic        rd_valid;
        logic [7:0]  rd_data;
        logic [9:0]  gap;
    } sfdpt_host_s_t;

    sfdpt_host_s_t s;
    sfdpt_host_s_t next_s;

    // Serial engine: 8 command bits, then address and dummy for table reads
    always_comb begin
        next_s          = s;
        next_s.miso_s   = {s.miso_s[0], link.miso};
        next_s.rd_valid = 1'b0;
        case (s.st)
            sfdpt_pkg::SFDPT_H_IDLE: begin
                if (start) begin
                    next_s.st   = sfdpt_pkg::SFDPT_H_SHIFT;
                    next_s.cs_n = 1'b0;
                    next_s.tx   = {opcode, addr, 8'h00, 8'h00};
                    next_s.nbits = (opcode == sfdpt_pkg::OP_READ_TABLE) ? 8'h28 : 8'h08; // see RULE22
                    next_s.left = (opcode == sfdpt_pkg::OP_READ_TABLE ||
                                   opcode == sfdpt_pkg::OP_READ_STATUS) ? nbytes : 8'h00; // see RULE21
                    next_s.rxn  = 3'h0;
                    next_s.div  = 2'h0;
                    next_s.gap  = (opcode == sfdpt_pkg::OP_DPD_ENTER) ? 10'(sfdpt_pkg::DPD_ENTER_CYC) :
                                  (opcode == sfdpt_pkg::OP_DPD_EXIT)  ? 10'(sfdpt_pkg::DPD_EXIT_CYC) :
                                  10'h004;                     // see RULE10
                end
            end
            sfdpt_pkg::SFDPT_H_SHIFT: begin
                next_s.div = s.div + 2'h1;
                // Slow sck leaves the device's sync chain room to see each edge
                if (s.div == 2'(sfdpt_pkg::SCK_DIV + 1)) begin
                    next_s.div = 2'h0;
                    next_s.sck = ~s.sck;
                    if (s.sck) begin
                        // Falling edge: advance transmit, or take a reply bit; the reply
                        // trails the pin fall by about five clocks (device sync plus ours),
                        // so it is taken at the end of the high phase, not at the rise
                        if (s.nbits != 8'h00) begin
                            next_s.tx    = {s.tx[46:0], 1'b0};
                            next_s.nbits = s.nbits - 8'h01;
                        end else if (s.left != 8'h00) begin
                            next_s.rx  = {s.rx[6:0], s.miso_s[1]};
                            next_s.rxn = s.rxn + 3'h1;
                            if (s.rxn == 3'h7) begin
                                next_s.rd_valid = 1'b1;
                                next_s.rd_data  = {s.rx[6:0], s.miso_s[1]};
                                next_s.left     = s.left - 8'h01;  // see RULE22
                            end
                        end
                        if (s.nbits <= 8'h01 && next_s.left == 8'h00) begin
                            next_s.st = sfdpt_pkg::SFDPT_H_DONE;
                        end
                    end
                end
            end
            sfdpt_pkg::SFDPT_H_DONE: begin
                next_s.cs_n = 1'b1;
                next_s.sck  = 1'b0;
                next_s.st   = sfdpt_pkg::SFDPT_H_WAIT;
            end
            sfdpt_pkg::SFDPT_H_WAIT: begin
                // Hold off after power-down transitions before next command
                next_s.gap = s.gap - 10'h001;                  // see RULE10
                if (s.gap <= 10'h001) begin
                    next_s.st = sfdpt_pkg::SFDPT_H_IDLE;
                end
            end
            default: begin
                next_s.st = sfdpt_pkg::SFDPT_H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '{st: sfdpt_pkg::SFDPT_H_IDLE, miso_s: 2'h0, tx: 48'h0,
                   nbits: 8'h00, rx: 8'h00, rxn: 3'h0, left: 8'h00, div: 2'h0,
                   sck: 1'b0, cs_n: 1'b1, rd_valid: 1'b0, rd_data: 8'h00,
                   gap: 10'h000};
        end else begin
            s <= next_s;
        end
    end

    assign link.cs_n = s.cs_n;
    assign link.sck  = s.sck;
    assign link.mosi = s.tx[47];
    assign ready     = (s.st == sfdpt_pkg::SFDPT_H_IDLE);
    assign rd_valid  = s.rd_valid;
    assign rd_data   = s.rd_data;
endmodule : sfdpt_host

// ---- verification/sfdpt_checker.sv ----
// Concurrent checks on the serial link between table device and host controller.
// Assumes one shared clock and a synchronous reset; instantiated beside the link.
module sfdpt_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       sck_d;
    logic [7:0] op_shift;
    logic [9:0] rises;
    logic [9:0] gap;
    logic [9:0] need;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Frame bookkeeping; gap saturates so the first frame after reset is never short
    always_ff @(posedge clk) begin
        if (rst) begin
            sck_d    <= 1'b0;
            op_shift <= 8'h00;
            rises    <= 10'h000;
            gap      <= 10'h3FF;
        end else begin
            sck_d <= sck;
            if (cs_n) rises <= 10'h000;
            else if (sck && !sck_d) rises <= rises + 10'h001;
            if (!cs_n && sck && !sck_d && rises < 10'h008) op_shift <= {op_shift[6:0], mosi};
            if (!cs_n) gap <= 10'h000;
            else if (gap != 10'h3FF) gap <= gap + 10'h001;
        end
    end
    // Quiet time owed after the last opcode sent
    always_comb begin
        if (op_shift == sfdpt_pkg::OP_DPD_ENTER) need = 10'(sfdpt_pkg::DPD_ENTER_CYC);
        else if (op_shift == sfdpt_pkg::OP_DPD_EXIT) need = 10'(sfdpt_pkg::DPD_EXIT_CYC);
        else need = 10'h004;
    end
    chk_sck_high_len: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
        else $error("serial clock high phase not four cycles");
    chk_sck_low_len: assert property ($fell(sck) |-> (!sck) [*4])
        else $error("serial clock low phase shorter than four cycles");
    chk_sck_idle_low: assert property (cs_n |-> !sck)
        else $error("serial clock moves outside a frame");
    chk_mosi_held_high: assert property (sck && $past(sck) |-> $stable(mosi))
        else $error("host data changed while serial clock high");
    chk_miso_held_high: assert property (!cs_n && sck && $past(sck) |-> $stable(miso))
        else $error("device data changed while serial clock high");
    chk_frame_whole_bytes: assert property ($rose(cs_n) |-> rises[2:0] == 3'h0 && rises >= 10'h008)
        else $error("frame not a whole number of bytes");
    chk_cmd_gap_len: assert property ($fell(cs_n) |-> gap >= need)
        else $error("next frame started too soon");
    chk_reset_idle_link: assert property ($fell(rst) |-> cs_n && !sck && !mosi && !miso)
        else $error("link not idle after reset");
endmodule : sfdpt_checker

// ---- verification/test_sfdp_parameter_table.sv ----
// Testbench joining the table device and the host controller across the link.
// Assumes the design package and link interface are compiled first.
module test_sfdp_parameter_table;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [191:0] MAP_EXP = 192'hFF0004FF_F37F0000_F57F0000_F9FF1D00_F57F0000_F37F0000;
    localparam logic [607:0] VEND_EXP = {sfdpt_pkg::ID_MAKER, sfdpt_pkg::ID_TYPE, sfdpt_pkg::ID_PART, 8'hFF,
        288'hB9DFFDFF_FFFFFFFF_32FF0A12_2346FF0F_19320F19_19030AFF_FFFFFFFF_00669938_FF050135,
        288'h06040232_B0307242_8DE89888_A585C09F_AF5AB9AB_06EC060C_0003080B_FFFFFFFF_FF07FFFF};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        start = 1'b0;
    logic [7:0]  opcode = 8'h00;
    logic [23:0] addr = 24'h000000;
    logic [7:0]  nbytes = 8'h00;
    logic        busy_in = 1'b0;
    logic        ready;
    logic        rd_valid;
    logic [7:0]  rd_data;
    logic        dpd_active;
    logic        in_reset;
    logic [7:0]  got [$];
    int          miscompares = 0;
    int          checks_done = 0;
    int          pulses = 0;
    sfdpt_link_if sfdpt_link_if_inst ();
    sfdpt_device sfdpt_device_inst (.clk(clk), .rst(rst), .link(sfdpt_link_if_inst.dev), .busy_in(busy_in),
        .dpd_active(dpd_active), .in_reset(in_reset));
    sfdpt_host sfdpt_host_inst (.clk(clk), .rst(rst), .link(sfdpt_link_if_inst.host), .start(start),
        .opcode(opcode), .addr(addr), .nbytes(nbytes), .ready(ready), .rd_valid(rd_valid), .rd_data(rd_data));
    sfdpt_checker sfdpt_checker_inst (.clk(clk), .rst(rst), .cs_n(sfdpt_link_if_inst.cs_n),
        .sck(sfdpt_link_if_inst.sck), .mosi(sfdpt_link_if_inst.mosi), .miso(sfdpt_link_if_inst.miso));
    // Clock and reset-pulse counter
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        if (in_reset === 1'b1) pulses++;
    end
    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] seen);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk8
    task automatic chk1(input string name, input logic exp, input logic seen);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %b seen %b", name, exp, seen);
        end
    endtask : chk1
    // One command on the host port; bytes are collected until ready returns
    task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] n);
        int k;
        got.delete();
        k = 0;
        while (ready !== 1'b1 && k < 2000) begin
            @(posedge clk);
            k++;
        end
        @(posedge clk);
        start  <= 1'b1;
        opcode <= op;
        addr   <= a;
        nbytes <= n;
        @(posedge clk);
        start <= 1'b0;
        k = 0;
        do begin
            @(posedge clk);
            #1;
            if (rd_valid === 1'b1) got.push_back(rd_data);
            k++;
        end while (ready !== 1'b1 && k < 20000);
        chk1("command finished", 1'b1, ready);
    endtask : cmd
    task automatic test_map();
        cmd(sfdpt_pkg::OP_READ_TABLE, 24'h000100, 8'h18);
        chk8("map count", 8'h18, 8'(got.size()));
        for (int i = 0; i < 24; i++) begin
            chk8("map byte", MAP_EXP[191 - 8 * i -: 8], got[i]);
        end
        $display("test map done");
    endtask : test_map
    task automatic test_vendor();
        cmd(sfdpt_pkg::OP_READ_TABLE, 24'h000200, 8'h4C);
        chk8("vendor count", 8'h4C, 8'(got.size()));
        for (int i = 0; i < 32; i++) begin
            chk8("vendor caps", VEND_EXP[607 - 8 * i -: 8], got[i]);
        end
        for (int i = 32; i < 76; i++) begin
            chk8("vendor ops", VEND_EXP[607 - 8 * i -: 8], got[i]);
        end
        chk8("vendor reserved", 8'hFF, got[3]);
        chk8("power-down enter time", 8'h03, got[25]);
        chk8("power-down exit time", 8'h0A, got[26]);
        chk8("security id size low", 8'hFF, got[72]);
        chk8("security id size high", 8'h07, got[73]);
        $display("test vendor done");
    endtask : test_vendor
    // Four-byte addressing bytes, reserved tail and unmapped space
    task automatic test_edges();
        cmd(sfdpt_pkg::OP_READ_TABLE, 24'h00006E, 8'h02);
        chk8("exit four-byte", 8'hC0, got[0]);
        chk8("enter four-byte", 8'h80, got[1]);
        cmd(sfdpt_pkg::OP_READ_TABLE, 24'h00024A, 8'h03);
        for (int i = 0; i < 3; i++) chk8("reserved tail", 8'hFF, got[i]);
        cmd(sfdpt_pkg::OP_READ_TABLE, 24'h000118, 8'h02);
        for (int i = 0; i < 2; i++) chk8("unmapped", 8'hFF, got[i]);
        $display("test edges done");
    endtask : test_edges
    task automatic test_status();
        @(posedge clk);
        busy_in <= 1'b1;
        cmd(sfdpt_pkg::OP_READ_STATUS, 24'h000000, 8'h01);
        chk8("status busy", 8'h01, got[0]);
        @(posedge clk);
        busy_in <= 1'b0;
        cmd(sfdpt_pkg::OP_READ_STATUS, 24'h000000, 8'h01);
        chk8("status ready", 8'h00, got[0]);
        $display("test status done");
    endtask : test_status
    task automatic test_power_down();
        cmd(sfdpt_pkg::OP_DPD_ENTER, 24'h000000, 8'h00);
        chk1("power-down entered", 1'b1, dpd_active);
        cmd(sfdpt_pkg::OP_DPD_EXIT, 24'h000000, 8'h00);
        chk1("power-down left", 1'b0, dpd_active);
        $display("test power-down done");
    endtask : test_power_down
    // Lone reset, paired reset, and a pair broken by another command
    task automatic test_reset_seq();
        int p0;
        p0 = pulses;
        cmd(sfdpt_pkg::OP_RST_MEM, 24'h000000, 8'h00);
        chk8("lone reset", 8'h00, 8'(pulses - p0));
        p0 = pulses;
        cmd(sfdpt_pkg::OP_RST_EN, 24'h000000, 8'h00);
        cmd(sfdpt_pkg::OP_RST_MEM, 24'h000000, 8'h00);
        chk8("paired reset", 8'h01, 8'(pulses - p0));
        p0 = pulses;
        cmd(sfdpt_pkg::OP_RST_EN, 24'h000000, 8'h00);
        cmd(sfdpt_pkg::OP_READ_STATUS, 24'h000000, 8'h01);
        cmd(sfdpt_pkg::OP_RST_MEM, 24'h000000, 8'h00);
        chk8("broken pair", 8'h00, 8'(pulses - p0));
        $display("test reset sequence done");
    endtask : test_reset_seq
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        test_map();
        test_vendor();
        test_edges();
        test_status();
        test_power_down();
        test_reset_seq();
        report_and_stop();
    end
    // Watchdog well beyond the roughly ten thousand cycles the tests need
    initial begin
        #(25 * 60000);
        miscompares++;
        report_and_stop();
    end
endmodule : test_sfdp_parameter_table
